// File: sofs_counter.sv
// Fast-settle timeout counter running on phase-detector cycles.
`timescale 1ns/1ps
`default_nettype none
module sofs_counter (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [13:0] timeout,
  input  wire logic        pd_tick,
  output logic             running
);
  logic [14:0] cnt_ff;
  logic [14:0] nxt_cnt;

  // Load twice the timeout on start, then count down once per detector cycle.
  assign nxt_cnt = start ? {timeout, 1'b0}
                 : ((pd_tick && cnt_ff != 15'h0000) ? cnt_ff - 15'h0001 : cnt_ff);
  assign running = (cnt_ff != 15'h0000);

  // ************************************************************
  // Counter register
  // ************************************************************
  // Loading from start restarts even a running count.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 15'h0000;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule // sofs_counter
`default_nettype wire

// File: sofs_host_model.sv
// Host model that programs the output and fast-settle words.
`timescale 1ns/1ps
`default_nettype none
module sofs_host_model (
  input  wire logic        clk,
  output var  logic        wr_stb,
  output var  logic [1:0]  wr_sel,
  output var  logic [31:0] wr_data,
  output var  logic        freq_prog
);
  // ****************************************
  // Programming port
  // ****************************************
  // Quiet bus; data is inverted after each word so a stale word never looks valid.
  initial begin
    wr_stb    = 1'b0;
    wr_sel    = 2'h0;
    wr_data   = 32'h0;
    freq_prog = 1'b0;
  end
  // One word per call, held across one edge; callers pass only legal codes.
  task automatic write_word(input logic [1:0] sel, input logic [31:0] data);
    @(posedge clk);
    #1;
    wr_stb  = 1'b1;
    wr_sel  = sel;
    wr_data = data;
    @(posedge clk);
    #1;
    wr_stb  = 1'b0;
    wr_data = ~data;
  endtask
  // Announces a new output frequency, which restarts the timeout count for timeout codes above 3.
  task automatic prog_freq();
    @(posedge clk);
    #1;
    freq_prog = 1'b1;
    @(posedge clk);
    #1;
    freq_prog = 1'b0;
  endtask
endmodule // sofs_host_model
`default_nettype wire

// File: sofs_pkg.sv
// Package of field layouts, reset values and encodings for the output and fast-settle words.
package sofs_pkg;
  // ************************************************************
  // Word selection and field layout
  // ************************************************************
  localparam logic [1:0] SEL_DIVFILT = 2'h0;
  localparam logic [1:0] SEL_FASTSET = 2'h1;
  localparam logic [1:0] SEL_OUTPWR  = 2'h2;
  // Output power word fields.
  localparam int OE_LSB   = 0;
  localparam int DIVG_LSB = 4;
  localparam int OSCG_LSB = 8;
  localparam int TERM_LSB = 12;
  // Fast-settle word fields.
  localparam int TOC_LSB  = 0;
  localparam int FR3_LSB  = 14;
  localparam int FR4_LSB  = 17;
  localparam int FCPG_LSB = 20;
  // Divider and filter word fields.
  localparam int FREQ_LSB = 0;
  localparam int DIV_LSB  = 8;
  localparam int NR3_LSB  = 14;
  localparam int NR4_LSB  = 17;
  localparam int C3_LSB   = 20;
  // ************************************************************
  // Reset values and encodings
  // ************************************************************
  localparam logic [3:0]  PWR_RST   = 4'hc;
  localparam logic [1:0]  OE_OFF    = 2'h0;
  localparam logic [1:0]  OE_ON     = 2'h2;
  localparam logic [13:0] TOC_HIZ   = 14'h0000;
  localparam logic [13:0] TOC_ALWAYS = 14'h0001;
  localparam logic [13:0] TOC_LOW   = 14'h0002;
  localparam logic [13:0] TOC_HIGH  = 14'h0003;
  localparam logic [5:0]  DIV_BYPASS = 6'h01;
  localparam logic [5:0]  DIV_RST   = 6'h02;
  localparam logic [7:0]  FREQ_RST  = 8'h01;
  localparam logic [1:0]  MODE_FULL = 2'h0;
  localparam logic [1:0]  MODE_EXTOSC = 2'h1;
  localparam logic [1:0]  MODE_DIVONLY = 2'h2;
  localparam logic [1:0]  MODE_TEST = 2'h3;
  localparam logic [2:0]  RES_RST   = 3'h0;
  localparam logic [3:0]  CAP_RST   = 4'h0;
  localparam logic [4:0]  PUMP_RST  = 5'h00;
endpackage : sofs_pkg

// File: sofs_regs.sv
// Output gating, power, fast-settle and divider/filter word registers.
`timescale 1ns/1ps
`default_nettype none
module sofs_regs (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wr_stb,
  input  wire logic [1:0]  wr_sel,
  input  wire logic [31:0] wr_data,
  input  wire logic        freq_prog,
  input  wire logic        pd_tick,
  input  wire logic [1:0]  op_mode,
  input  wire logic        output_enable_pin,
  output logic             rf_output_on,
  output logic [3:0]       output_termination_level,
  output logic [3:0]       active_buffer_gain,
  output logic             fast_settle_pin_o,
  output logic             fast_settle_pin_oe,
  output logic             fast_settle_engaged,
  output logic [4:0]       pump_gain,
  output logic [2:0]       loop_resistor_three,
  output logic [2:0]       loop_resistor_four,
  output logic             filter_apply,
  output logic [3:0]       filter_capacitor_three,
  output logic [5:0]       output_divide_ratio,
  output logic             divider_bypass,
  output logic [7:0]       reference_freq_mhz,
  output logic             divider_resync
);
  // ************************************************************
  // Stored fields
  // ************************************************************
  logic [1:0]  output_enable_select_ff;
  logic [3:0]  divider_buffer_gain_ff;
  logic [3:0]  osc_buffer_gain_ff;
  logic [3:0]  output_termination_level_ff;
  logic [13:0] fast_settle_timeout_ff;
  logic [2:0]  fast_settle_resistor_three_ff;
  logic [2:0]  fast_settle_resistor_four_ff;
  logic [4:0]  fast_settle_pump_gain_ff;
  logic [4:0]  normal_pump_gain_ff;
  logic [7:0]  reference_freq_mhz_ff;
  logic [5:0]  output_divide_ratio_ff;
  logic [2:0]  filter_resistor_three_ff;
  logic [2:0]  filter_resistor_four_ff;
  logic [3:0]  filter_capacitor_three_ff;
  logic        divider_resync_ff;
  logic        counter_running;

  // Write decodes for each word.
  wire wr_pwr = wr_stb && (wr_sel == sofs_pkg::SEL_OUTPWR);
  wire wr_fs  = wr_stb && (wr_sel == sofs_pkg::SEL_FASTSET);
  wire wr_df  = wr_stb && (wr_sel == sofs_pkg::SEL_DIVFILT);

  // Output power word.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      output_enable_select_ff     <= sofs_pkg::OE_OFF;
      divider_buffer_gain_ff      <= sofs_pkg::PWR_RST;
      osc_buffer_gain_ff          <= sofs_pkg::PWR_RST;
      output_termination_level_ff <= sofs_pkg::PWR_RST;
    end else if (wr_pwr) begin
      output_enable_select_ff     <= wr_data[sofs_pkg::OE_LSB +: 2];
      divider_buffer_gain_ff      <= wr_data[sofs_pkg::DIVG_LSB +: 4];
      osc_buffer_gain_ff          <= wr_data[sofs_pkg::OSCG_LSB +: 4];
      output_termination_level_ff <= wr_data[sofs_pkg::TERM_LSB +: 4];
    end
  end

  // Fast-settle word: timeout, alternate resistor codes and alternate pump gain.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fast_settle_timeout_ff        <= sofs_pkg::TOC_HIZ;
      fast_settle_resistor_three_ff <= sofs_pkg::RES_RST;
      fast_settle_resistor_four_ff  <= sofs_pkg::RES_RST;
      fast_settle_pump_gain_ff      <= sofs_pkg::PUMP_RST;
    end else if (wr_fs) begin
      fast_settle_timeout_ff        <= wr_data[sofs_pkg::TOC_LSB +: 14];
      fast_settle_resistor_three_ff <= wr_data[sofs_pkg::FR3_LSB +: 3];
      fast_settle_resistor_four_ff  <= wr_data[sofs_pkg::FR4_LSB +: 3];
      fast_settle_pump_gain_ff      <= wr_data[sofs_pkg::FCPG_LSB +: 5];
    end
  end

  // Divider and filter word; each write also pulses the resynchronise strobe.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reference_freq_mhz_ff     <= sofs_pkg::FREQ_RST;
      output_divide_ratio_ff    <= sofs_pkg::DIV_RST;
      filter_resistor_three_ff  <= sofs_pkg::RES_RST;
      filter_resistor_four_ff   <= sofs_pkg::RES_RST;
      filter_capacitor_three_ff <= sofs_pkg::CAP_RST;
    end else if (wr_df) begin
      reference_freq_mhz_ff     <= wr_data[sofs_pkg::FREQ_LSB +: 8];
      output_divide_ratio_ff    <= wr_data[sofs_pkg::DIV_LSB +: 6];
      filter_resistor_three_ff  <= wr_data[sofs_pkg::NR3_LSB +: 3];
      filter_resistor_four_ff   <= wr_data[sofs_pkg::NR4_LSB +: 3];
      filter_capacitor_three_ff <= wr_data[sofs_pkg::C3_LSB +: 4];
    end
  end

  // The normal pump gain belongs to a word outside this block; it stays at reset.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      normal_pump_gain_ff <= sofs_pkg::PUMP_RST;
      divider_resync_ff   <= 1'b0;
    end else begin
      normal_pump_gain_ff <= normal_pump_gain_ff;
      divider_resync_ff   <= wr_df;
    end
  end

  // ************************************************************
  // Fast-settle timing
  // ************************************************************
  // Short timeouts never load the counter, so a count never starts for them.
  wire toc_counts = (fast_settle_timeout_ff > sofs_pkg::TOC_HIGH);
  sofs_counter u_counter (
    .clk     (clk),
    .rst     (rst),
    .start   (freq_prog && toc_counts),
    .timeout (fast_settle_timeout_ff),
    .pd_tick (pd_tick),
    .running (counter_running)
  );

  // Engaged while counting, or permanently for the always-on code.
  assign fast_settle_engaged = counter_running ||
                               (fast_settle_timeout_ff == sofs_pkg::TOC_ALWAYS);
  // Pin: a running count grounds it first, so rewriting a short code mid-count
  // cannot release the pin while the pump is still in its fast setting.
  assign fast_settle_pin_oe = counter_running ||
                              (!toc_counts &&
                               (fast_settle_timeout_ff != sofs_pkg::TOC_HIZ));
  assign fast_settle_pin_o  = !counter_running && !toc_counts &&
                              (fast_settle_timeout_ff == sofs_pkg::TOC_HIGH);

  // ************************************************************
  // Output gating and power selection
  // ************************************************************
  assign rf_output_on = (output_enable_select_ff == sofs_pkg::OE_ON) ||
                        (output_enable_select_ff[0] && output_enable_pin);
  assign divider_bypass = (output_divide_ratio_ff == sofs_pkg::DIV_BYPASS);
  assign output_termination_level = output_termination_level_ff;
  assign active_buffer_gain = divider_bypass ? osc_buffer_gain_ff
                                             : divider_buffer_gain_ff;

  // ************************************************************
  // Pump and filter selection
  // ************************************************************
  // Codes pass unchanged; the analog side decodes 200R,1k,2k,4k,16k.
  assign pump_gain = fast_settle_engaged ? fast_settle_pump_gain_ff
                                         : normal_pump_gain_ff;
  assign loop_resistor_three = fast_settle_engaged ? fast_settle_resistor_three_ff
                                                   : filter_resistor_three_ff;
  assign loop_resistor_four = fast_settle_engaged ? fast_settle_resistor_four_ff
                                                  : filter_resistor_four_ff;
  assign filter_apply = (op_mode == sofs_pkg::MODE_FULL);
  assign filter_capacitor_three = filter_capacitor_three_ff;
  assign output_divide_ratio = output_divide_ratio_ff;
  assign reference_freq_mhz = reference_freq_mhz_ff;
  assign divider_resync = divider_resync_ff;

  // ************************************************************
  // Checks
  // ************************************************************
  sequence fs_load_s;
    freq_prog && toc_counts;
  endsequence
  sequence fs_held_s;
    fast_settle_pin_oe && !fast_settle_pin_o;
  endsequence
  pin_on_a: assert property (@(posedge clk) disable iff (rst)
    (output_enable_select_ff == sofs_pkg::OE_OFF) |-> !rf_output_on)
    else $error("Output on while selector forces off.");
  pin_follow_a: assert property (@(posedge clk) disable iff (rst)
    output_enable_select_ff[0] |-> (rf_output_on == output_enable_pin))
    else $error("Output does not follow enable pin.");
  gain_sel_a: assert property (@(posedge clk) disable iff (rst)
    divider_bypass |-> (active_buffer_gain == osc_buffer_gain_ff))
    else $error("Wrong gain word in bypass.");
  pwr_reset_a: assert property (@(posedge clk) disable iff (rst)
    $rose(!rst) |-> (output_termination_level == sofs_pkg::PWR_RST))
    else $error("Power word reset value wrong.");
  fs_engage_a: assert property (@(posedge clk) disable iff (rst)
    fs_load_s ##1 !pd_tick |=> fast_settle_engaged)
    else $error("Fast settle not engaged after load.");
  fs_pin_a: assert property (@(posedge clk) disable iff (rst)
    counter_running |-> fs_held_s)
    else $error("Pin not grounded while counting.");
  fs_small_a: assert property (@(posedge clk) disable iff (rst)
    (fast_settle_timeout_ff == sofs_pkg::TOC_HIZ) && !counter_running |-> !fast_settle_pin_oe)
    else $error("Pin driven for code zero.");
  pump_sel_a: assert property (@(posedge clk) disable iff (rst)
    fast_settle_engaged |-> (pump_gain == fast_settle_pump_gain_ff))
    else $error("Fast pump gain not selected.");
  resync_a: assert property (@(posedge clk) disable iff (rst)
    wr_df |=> divider_resync)
    else $error("Resync pulse missing.");
  resync_once_a: assert property (@(posedge clk) disable iff (rst)
    !wr_df |=> !divider_resync)
    else $error("Resync pulse without a divider write.");
endmodule // sofs_regs
`default_nettype wire

// File: synth_output_fastsettle_regs_tb.sv
// Self-checking bench for the output and fast-settle word registers.
`timescale 1ns/1ps
`default_nettype none
module synth_output_fastsettle_regs_tb;
  logic clk, rst, pd_tick, output_enable_pin, wr_stb, freq_prog, rf_output_on;
  logic fast_settle_pin_o, fast_settle_pin_oe, fast_settle_engaged, filter_apply;
  logic divider_bypass, divider_resync;
  logic [1:0] wr_sel, op_mode;
  logic [31:0] wr_data;
  logic [3:0] output_termination_level, active_buffer_gain, filter_capacitor_three;
  logic [4:0] pump_gain;
  logic [2:0] loop_resistor_three, loop_resistor_four;
  logic [5:0] output_divide_ratio;
  logic [7:0] reference_freq_mhz;
  int fail_count = 0;
  int cmp_count = 0;
  int ticks;
  sofs_regs i_dut (.clk(clk), .rst(rst), .wr_stb(wr_stb), .wr_sel(wr_sel), .wr_data(wr_data),
    .freq_prog(freq_prog), .pd_tick(pd_tick), .op_mode(op_mode),
    .output_enable_pin(output_enable_pin), .rf_output_on(rf_output_on),
    .output_termination_level(output_termination_level),
    .active_buffer_gain(active_buffer_gain), .fast_settle_pin_o(fast_settle_pin_o),
    .fast_settle_pin_oe(fast_settle_pin_oe), .fast_settle_engaged(fast_settle_engaged),
    .pump_gain(pump_gain), .loop_resistor_three(loop_resistor_three),
    .loop_resistor_four(loop_resistor_four), .filter_apply(filter_apply),
    .filter_capacitor_three(filter_capacitor_three), .output_divide_ratio(output_divide_ratio),
    .divider_bypass(divider_bypass), .reference_freq_mhz(reference_freq_mhz),
    .divider_resync(divider_resync));
  sofs_host_model i_host (.clk(clk), .wr_stb(wr_stb), .wr_sel(wr_sel), .wr_data(wr_data),
    .freq_prog(freq_prog));
  // ****************************************
  // Clock, ticks and verdict
  // ****************************************
  // Clock and a phase-detector tick on every other cycle.
  initial clk = 1'b0;
  always #5 clk = ~clk;
  always @(posedge clk) #1 pd_tick = ~pd_tick;
  // Compares one value; four-state equality so an unknown never matches a known value.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // The run needs well under 2000 cycles; this limit only catches a hang.
  initial begin
    #100us;
    fail_count++;
    end_of_test();
  end
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    pd_tick = 1'b0;
    output_enable_pin = 1'b0;
    op_mode = 2'h0;
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    // Reset state: output off, gains 12, pin floating, ratio 2, reference 1.
    check(rf_output_on, 0);
    check(output_termination_level, 12);
    check(active_buffer_gain, 12);
    check(fast_settle_pin_oe, 0);
    check(output_divide_ratio, 2);
    check(reference_freq_mhz, 1);
    // Every selector value against both pin levels; ratio 2 uses the divider gain.
    for (int s = 0; s < 4; s++) begin
      i_host.write_word(2'h2, 32'h00009530 | s);
      for (int p = 0; p < 2; p++) begin
        @(posedge clk);
        #1 output_enable_pin = p[0];
        #1 check(rf_output_on, (s == 2) || (s[0] && p[0]));
      end
      check(output_termination_level, 9);
      check(active_buffer_gain, 3);
    end
    // Divider word: bypass picks the oscillator gain, and each write resyncs.
    for (int d = 1; d < 6; d += 3) begin
      i_host.write_word(2'h0, 32'h00f28019 | (d << 8));
      check(divider_resync, 1);
      check(output_divide_ratio, d);
      check(divider_bypass, d == 1);
      check(active_buffer_gain, (d == 1) ? 5 : 3);
      check(reference_freq_mhz, 8'h19);
      check(filter_capacitor_three, 15);
      @(posedge clk);
      #1 check(divider_resync, 0);
    end
    check(loop_resistor_three, 2);
    check(loop_resistor_four, 1);
    // Filter settings apply in full mode only.
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      #1 op_mode = m[1:0];
      #1 check(filter_apply, m == 0);
    end
    @(posedge clk);
    #1 op_mode = 2'h0;
    // Timeout values 1 to 3 turn the pin into a plain output; value 0 leaves it floating.
    for (int t = 0; t < 4; t++) begin
      i_host.write_word(2'h1, t);
      check(fast_settle_pin_oe, t != 0);
      check(fast_settle_pin_o, t == 3);
      check(fast_settle_engaged, t == 1);
    end
    // Timeout 4 engages for eight ticks with the fast-settle codes selected.
    i_host.write_word(2'h1, 32'h01f70004);
    check(fast_settle_engaged, 0);
    check(fast_settle_pin_oe, 0);
    i_host.prog_freq();
    ticks = 0;
    for (int c = 0; c < 60; c++) begin
      @(negedge clk);
      if (fast_settle_engaged === 1'b1) begin
        check({fast_settle_pin_oe, fast_settle_pin_o}, 2'h2);
        check({pump_gain, loop_resistor_three, loop_resistor_four}, {5'h1f, 3'h4, 3'h3});
        if (pd_tick === 1'b1) ticks++;
      end
    end
    check(ticks, 8);
    check({fast_settle_pin_oe, pump_gain, loop_resistor_three}, {1'b0, 5'h00, 3'h2});
    end_of_test();
  end
endmodule // synth_output_fastsettle_regs_tb
`default_nettype wire
